// [src/scg_pkg.sv]
// shared constants and types of the sleep-mode clock gating block
// assumes a 32-bit AXI4-Lite register bus on the system clock
package scg_pkg;

   // ----------------------------------------------------------------
   // register offsets (byte addresses in the system control space)
   // ----------------------------------------------------------------
   localparam logic [11:0] SCG_OFS_SLEEP_GATE  = 12'h0110;
   localparam logic [11:0] SCG_OFS_IRQ_STATUS  = 12'h0150;
   localparam logic [11:0] SCG_OFS_IRQ_MASK    = 12'h0154;

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int          SCG_BIT_CONV        = 16;
   localparam int          SCG_BIT_RATE_LO     = 8;
   localparam int          SCG_BIT_FIXED_ONE   = 6;
   localparam int          SCG_BIT_WDOG        = 3;
   localparam logic [31:0] SCG_GATE_RESET      = 32'h0000_0040;
   localparam logic [1:0]  SCG_RATE_250K       = 2'h1;
   localparam logic [1:0]  SCG_RATE_125K       = 2'h0;
   localparam int          SCG_NUM_UNITS       = 2;
   localparam int          SCG_UNIT_CONV       = 0;
   localparam int          SCG_UNIT_WDOG       = 1;

   // ----------------------------------------------------------------
   // bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0]  SCG_RESP_OKAY       = 2'h0;
   localparam logic [1:0]  SCG_RESP_SLVERR     = 2'h2;
   localparam logic [1:0]  SCG_RESP_DECERR     = 2'h3;

   typedef enum logic [1:0] {
      SCG_SEL_NONE,
      SCG_SEL_GATE,
      SCG_SEL_STATUS,
      SCG_SEL_MASK
   } scg_sel_t;

   // writable fields of one gating register
   typedef struct packed {
      logic       conv;
      logic [1:0] rate;
      logic       wdog;
   } scg_gate_t;

   // one access offered to a controlled unit by the fabric
   typedef struct packed {
      logic valid;
      logic write;
   } scg_access_t;

endpackage

// [src/scg_unit_gate.sv]
// clock enable and access check for one controlled unit
// assumes mode and gating inputs come from logic on the same clock
`timescale 1ns/1ns
module scg_unit_gate (
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   input  wire logic              runEn,
   input  wire logic              sleepEn,
   input  wire logic              deepEn,
   input  wire logic              sleepMode,
   input  wire logic              deepMode,
   input  wire logic              autoGating,
   input  wire scg_pkg::scg_access_t access,
   output logic                   clockEnable_reg,
   output logic                   fault_reg,
   output logic                   okay_reg
);

   logic clockEnable_next;

   // ----------------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------------
   // without auto gating the run setting holds in every mode
   always_comb begin
      clockEnable_next = runEn;                                 // RQ5
      if (autoGating && deepMode) begin                         // RQ6
         clockEnable_next = deepEn;                             // RQ5
      end else if (autoGating && sleepMode) begin               // RQ6
         clockEnable_next = sleepEn;                            // RQ1
      end
   end

   // registered so the downstream clock gate sees a clean level
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clockEnable_reg <= 1'b0;                               // RQ4
      end else begin
         clockEnable_reg <= clockEnable_next;                   // RQ2
      end
   end

   // ----------------------------------------------------------------
   // access check: a gated unit answers every access with a fault
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_reg <= 1'b0;
         okay_reg  <= 1'b0;
      end else begin
         fault_reg <= access.valid && !clockEnable_reg;         // RQ3
         okay_reg  <= access.valid && clockEnable_reg;          // RQ14
      end
   end

endmodule // scg_unit_gate

// [src/scg_sleep_clock_gating.sv]
// sleep-mode clock gating register with AXI4-Lite slave and fault irq
// assumes mode inputs and the run/deep-sleep gating words are synchronous
// to core_clk; clock enables feed glitch-free clock gates elsewhere
//
// Operation
// RQ1: a set gating bit keeps its unit clocked during sleep.
// RQ2: a clear gating bit stops the unit's clock.
// RQ3: access to a unit whose clock is off ends in a bus fault.
// RQ4: all gating bits reset to zero, units start unclocked.
// RQ5: run word when running, sleep word in sleep, deep word in deep sleep; converter_sample_rate takes the run word in deep sleep.
// RQ6: sleep and deep settings apply only with auto gating selected.
// RQ7: bit 16 is the read-write gating bit of converter 0.
// RQ8: bits 9:8 set converter sample rate, 1 is 250K, 0 is 125K.
// RQ9: bit 3 is the read-write gating bit of the watchdog.
// RQ10: register reads 0x00000040 after reset; reserved bit 6 reads one.
// RQ11: the register decodes at offset 0x110.
// RQ12: software keeps reserved bits and does not depend on them.
// RQ13: software enables a unit's clock before accessing it.
// RQ14: a faulted access errors on its own transfer, write has no effect.
`timescale 1ns/1ns
module scg_sleep_clock_gating #(
   parameter int ADDR_W = 12
) (
   input  wire logic              core_clk,
   input  wire logic              arst_n,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // power mode and the sibling gating words
   input  wire logic              sleepMode,
   input  wire logic              deepSleepMode,
   input  wire logic              auto_gating_select,
   input  wire logic [31:0]       run_clock_gate_reg,
   input  wire logic [31:0]       deepsleep_clock_gate_reg,
   // accesses offered to the controlled units
   input  wire scg_pkg::scg_access_t convAccess,
   input  wire scg_pkg::scg_access_t wdogAccess,
   // unit side
   output logic                   convClockEnable,
   output logic                   watchdog_clock_gate,
   output logic [1:0]             converter_sample_rate,
   output logic                   convAccessFault,
   output logic                   convAccessOkay,
   output logic                   wdogAccessFault,
   output logic                   wdogAccessOkay,
   output logic                   irq
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic scg_pkg::scg_sel_t decodeAddr(
      input logic [ADDR_W-1:0] addr
   );
      logic [11:0] ofs;
      ofs = 12'(addr);
      unique case (ofs)
         scg_pkg::SCG_OFS_SLEEP_GATE: decodeAddr = scg_pkg::SCG_SEL_GATE;
         scg_pkg::SCG_OFS_IRQ_STATUS: decodeAddr = scg_pkg::SCG_SEL_STATUS;
         scg_pkg::SCG_OFS_IRQ_MASK:   decodeAddr = scg_pkg::SCG_SEL_MASK;
         default:                     decodeAddr = scg_pkg::SCG_SEL_NONE;
      endcase
   endfunction

   function automatic logic [31:0] gateWord(input scg_pkg::scg_gate_t g);
      logic [31:0] w;
      w = scg_pkg::SCG_GATE_RESET;                              // RQ10
      w[scg_pkg::SCG_BIT_CONV] = g.conv;
      w[scg_pkg::SCG_BIT_RATE_LO +: 2] = g.rate;
      w[scg_pkg::SCG_BIT_WDOG] = g.wdog;
      gateWord = w;
   endfunction

   scg_pkg::scg_gate_t          gate_reg;
   logic [ADDR_W-1:0]           wrAddr_reg;
   logic [31:0]                 wrData_reg;
   logic [3:0]                  wrStrb_reg;
   logic                        awGot_reg;
   logic                        wGot_reg;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] status_reg;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] mask_reg;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] faultEvent;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] okayEvent;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] enableVec;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] runVec;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] sleepVec;
   logic [scg_pkg::SCG_NUM_UNITS-1:0] deepVec;
   scg_pkg::scg_access_t        accessVec [scg_pkg::SCG_NUM_UNITS];
   scg_pkg::scg_sel_t           wrSel;
   logic                        doWrite;
   logic                        doRead;
   logic [31:0]                 wrMerged;

   assign doWrite = awGot_reg && wGot_reg && !s_axi_bvalid;
   assign doRead  = s_axi_arvalid && s_axi_arready;
   assign wrSel   = decodeAddr(wrAddr_reg);

   // byte lanes merge into the current word; reserved bits are dropped
   always_comb begin
      wrMerged = gateWord(gate_reg);
      for (int b = 0; b < 4; b++) begin
         if (wrStrb_reg[b]) begin
            wrMerged[8*b +: 8] = wrData_reg[8*b +: 8];
         end
      end
   end

   // ----------------------------------------------------------------
   // write channels: address and data taken in either order
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         awGot_reg     <= 1'b0;
         wGot_reg      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         wrAddr_reg    <= '0;
         wrData_reg    <= '0;
         wrStrb_reg    <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awGot_reg  <= 1'b1;
            wrAddr_reg <= s_axi_awaddr;
         end else if (doWrite) begin
            awGot_reg  <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wGot_reg   <= 1'b1;
            wrData_reg <= s_axi_wdata;
            wrStrb_reg <= s_axi_wstrb;
         end else if (doWrite) begin
            wGot_reg   <= 1'b0;
         end
         s_axi_awready <= !awGot_reg && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !wGot_reg && !s_axi_wready && !s_axi_bvalid;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= scg_pkg::SCG_RESP_OKAY;
      end else if (doWrite) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (wrSel == scg_pkg::SCG_SEL_NONE) ?
                         scg_pkg::SCG_RESP_DECERR : scg_pkg::SCG_RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // sleep gating register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_reg <= '0;                                        // RQ4
      end else if (doWrite && wrSel == scg_pkg::SCG_SEL_GATE) begin // RQ11
         gate_reg.conv <= wrMerged[scg_pkg::SCG_BIT_CONV];      // RQ7
         gate_reg.rate <= wrMerged[scg_pkg::SCG_BIT_RATE_LO +: 2]; // RQ8
         gate_reg.wdog <= wrMerged[scg_pkg::SCG_BIT_WDOG];      // RQ9
      end
   end

   // ----------------------------------------------------------------
   // fault status, mask and interrupt
   // ----------------------------------------------------------------
   // a fault in the clearing cycle survives: set wins over clear
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         status_reg <= '0;
      end else if (doWrite && wrSel == scg_pkg::SCG_SEL_STATUS &&
                   wrStrb_reg[0]) begin
         status_reg <= (status_reg & ~wrData_reg[1:0]) | faultEvent;
      end else begin
         status_reg <= status_reg | faultEvent;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         mask_reg <= '0;
      end else if (doWrite && wrSel == scg_pkg::SCG_SEL_MASK &&
                   wrStrb_reg[0]) begin
         mask_reg <= wrData_reg[1:0];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |((status_reg | faultEvent) & mask_reg);
      end
   end

   // ----------------------------------------------------------------
   // read channel: one cycle from address to data
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= scg_pkg::SCG_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (doRead) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= scg_pkg::SCG_RESP_OKAY;
            unique case (decodeAddr(s_axi_araddr))
               scg_pkg::SCG_SEL_GATE:   s_axi_rdata <= gateWord(gate_reg);
               scg_pkg::SCG_SEL_STATUS: s_axi_rdata <= {30'h0, status_reg};
               scg_pkg::SCG_SEL_MASK:   s_axi_rdata <= {30'h0, mask_reg};
               scg_pkg::SCG_SEL_NONE: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= scg_pkg::SCG_RESP_DECERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // per-unit enables and access checks
   // ----------------------------------------------------------------
   assign runVec   = {run_clock_gate_reg[scg_pkg::SCG_BIT_WDOG],
                      run_clock_gate_reg[scg_pkg::SCG_BIT_CONV]};
   assign deepVec  = {deepsleep_clock_gate_reg[scg_pkg::SCG_BIT_WDOG],
                      deepsleep_clock_gate_reg[scg_pkg::SCG_BIT_CONV]};
   assign sleepVec = {gate_reg.wdog, gate_reg.conv};
   assign accessVec[scg_pkg::SCG_UNIT_CONV] = convAccess;
   assign accessVec[scg_pkg::SCG_UNIT_WDOG] = wdogAccess;

   for (genvar u = 0; u < scg_pkg::SCG_NUM_UNITS; u++) begin : g_unit
      scg_unit_gate u_gate (
         .core_clk        (core_clk),
         .arst_n          (arst_n),
         .runEn           (runVec[u]),
         .sleepEn         (sleepVec[u]),
         .deepEn          (deepVec[u]),
         .sleepMode       (sleepMode),
         .deepMode        (deepSleepMode),
         .autoGating      (auto_gating_select),
         .access          (accessVec[u]),
         .clockEnable_reg (enableVec[u]),
         .fault_reg       (faultEvent[u]),
         .okay_reg        (okayEvent[u])
      );
   end

   assign convClockEnable     = enableVec[scg_pkg::SCG_UNIT_CONV];
   assign watchdog_clock_gate = enableVec[scg_pkg::SCG_UNIT_WDOG];
   assign convAccessFault     = faultEvent[scg_pkg::SCG_UNIT_CONV];
   assign wdogAccessFault     = faultEvent[scg_pkg::SCG_UNIT_WDOG];
   assign convAccessOkay      = okayEvent[scg_pkg::SCG_UNIT_CONV];
   assign wdogAccessOkay      = okayEvent[scg_pkg::SCG_UNIT_WDOG];

   // rate follows the sleep word in auto-gated sleep and the run word in every other mode, deep sleep included
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         converter_sample_rate <= scg_pkg::SCG_RATE_125K;
      end else if (auto_gating_select && sleepMode && !deepSleepMode) begin
         converter_sample_rate <= gate_reg.rate;                // RQ8
      end else begin
         converter_sample_rate <=
            run_clock_gate_reg[scg_pkg::SCG_BIT_RATE_LO +: 2];  // RQ5
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic firstCycle_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         firstCycle_reg <= 1'b1;
      end else begin
         firstCycle_reg <= 1'b0;
      end
   end

   property p_sleep_on;
      @(posedge core_clk) disable iff (!arst_n)
      (sleepMode && !deepSleepMode && auto_gating_select && gate_reg.conv)
      |=> convClockEnable;
   endproperty
   a_sleep_on: assert property (p_sleep_on) // RQ1
      else $error("converter not clocked while enabled in sleep");

   property p_sleep_off;
      @(posedge core_clk) disable iff (!arst_n)
      (sleepMode && !deepSleepMode && auto_gating_select && !gate_reg.wdog)
      |=> !watchdog_clock_gate;
   endproperty
   a_sleep_off: assert property (p_sleep_off) // RQ2
      else $error("watchdog clock not stopped in sleep");

   property p_fault;
      @(posedge core_clk) disable iff (!arst_n)
      (wdogAccess.valid && !watchdog_clock_gate)
      |=> (wdogAccessFault && !wdogAccessOkay) ##1 status_reg[1];
   endproperty
   a_fault: assert property (p_fault) // RQ3
      else $error("access to gated watchdog not faulted");

   property p_okay;
      @(posedge core_clk) disable iff (!arst_n)
      (convAccess.valid && convClockEnable)
      |=> (convAccessOkay && !convAccessFault);
   endproperty
   a_okay: assert property (p_okay) // RQ14
      else $error("access to clocked converter faulted");

   property p_reset;
      @(posedge core_clk) disable iff (!arst_n)
      firstCycle_reg |-> (gate_reg == '0 && !convClockEnable);
   endproperty
   a_reset: assert property (p_reset) // RQ4
      else $error("gating state not cleared by reset");

   property p_run;
      @(posedge core_clk) disable iff (!arst_n)
      (!auto_gating_select || (!sleepMode && !deepSleepMode))
      |=> (watchdog_clock_gate == $past(run_clock_gate_reg[3]));
   endproperty
   a_run: assert property (p_run) // RQ6
      else $error("run gating not applied");

   property p_write_gate;
      @(posedge core_clk) disable iff (!arst_n)
      (doWrite && wrSel == scg_pkg::SCG_SEL_GATE && wrStrb_reg == 4'hf)
      |=> (gate_reg.conv == $past(wrData_reg[16]) &&
           gate_reg.wdog == $past(wrData_reg[3]));
   endproperty
   a_write_gate: assert property (p_write_gate) // RQ7
      else $error("gating bits not written");

   property p_write_rate;
      @(posedge core_clk) disable iff (!arst_n)
      (doWrite && wrSel == scg_pkg::SCG_SEL_GATE && wrStrb_reg[1])
      |=> (gate_reg.rate == $past(wrData_reg[9:8]));
   endproperty
   a_write_rate: assert property (p_write_rate) // RQ8
      else $error("rate field not written");

   property p_read_gate;
      @(posedge core_clk) disable iff (!arst_n)
      (doRead && s_axi_araddr == ADDR_W'(scg_pkg::SCG_OFS_SLEEP_GATE))
      |=> (s_axi_rvalid && s_axi_rdata[6] && s_axi_rdata[31:17] == '0 &&
           s_axi_rresp == scg_pkg::SCG_RESP_OKAY);
   endproperty
   a_read_gate: assert property (p_read_gate) // RQ10
      else $error("gating word read back wrong");

   property p_decode;
      @(posedge core_clk) disable iff (!arst_n)
      (doWrite && wrSel == scg_pkg::SCG_SEL_NONE)
      |=> (s_axi_bvalid && s_axi_bresp == scg_pkg::SCG_RESP_DECERR &&
           $stable(gate_reg));
   endproperty
   a_decode: assert property (p_decode) // RQ11
      else $error("unmapped write not refused");

   c_sleep_gate: cover property (@(posedge core_clk) disable iff (!arst_n)
      sleepMode && auto_gating_select ##1 convClockEnable);
   c_fault_irq: cover property (@(posedge core_clk) disable iff (!arst_n)
      convAccessFault ##1 irq);
   c_write: cover property (@(posedge core_clk) disable iff (!arst_n)
      doWrite && wrSel == scg_pkg::SCG_SEL_GATE);

endmodule // scg_sleep_clock_gating

// [sim/scg_cpu_model.sv]
// processor-side bus master driving the gating block's register bus
// assumes one caller at a time, tasks entered between clock edges
`timescale 1ns/1ns
module scg_cpu_model (
   input  wire logic        core_clk,
   output logic [11:0]      awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [11:0]      araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // released payload is inverted so a stale value is never mistaken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      logic ad;
      logic wd;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      ad = 1'h0;
      wd = 1'h0;
      while (!(ad && wd)) begin
         @(posedge core_clk);
         if (!ad && awready) begin
            ad = 1'h1;
            awvalid <= 1'h0;
            awaddr <= ~a;
         end
         if (!wd && wready) begin
            wd = 1'h1;
            wvalid <= 1'h0;
            wdata <= ~d;
         end
      end
      do @(posedge core_clk); while (!bvalid);
      r = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'h0;
      araddr <= ~a;
      do @(posedge core_clk); while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
endmodule // scg_cpu_model

// [sim/tb_top.sv]
// self-checking bench for the sleep-mode clock gating block
// assumes the bus model and the block share core_clk
`timescale 1ns/1ns
module tb_top;
   logic                 core_clk = 0;
   logic                 arst_n = 0;
   logic                 sleepMode = 1;
   logic                 deepMode = 0;
   logic                 autoGate = 1;
   logic [31:0]          runWord = 32'h0000_0108;
   logic [31:0]          deepWord = 32'h0001_0008;
   scg_pkg::scg_access_t convAcc = '0;
   scg_pkg::scg_access_t wdogAcc = '0;
   logic [11:0]          awaddr, araddr;
   logic [31:0]          wdata, rdata, rdv;
   logic [3:0]           wstrb;
   logic [1:0]           bresp, rresp, rate, rsp;
   logic                 awvalid, awready, wvalid, wready, bvalid, bready;
   logic                 arvalid, arready, rvalid, rready, irq;
   logic                 convEn, wdogEn, convFlt, convOk, wdogFlt, wdogOk;
   int                   error_cnt = 0;
   int                   n_compared = 0;
   int                   cycles = 0;
   always #5 core_clk = ~core_clk;
   scg_cpu_model cpu (.core_clk(core_clk), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   scg_sleep_clock_gating dut (.core_clk(core_clk), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sleepMode(sleepMode), .deepSleepMode(deepMode),
      .auto_gating_select(autoGate), .run_clock_gate_reg(runWord),
      .deepsleep_clock_gate_reg(deepWord), .convAccess(convAcc),
      .wdogAccess(wdogAcc), .convClockEnable(convEn),
      .watchdog_clock_gate(wdogEn), .converter_sample_rate(rate),
      .convAccessFault(convFlt), .convAccessOkay(convOk),
      .wdogAccessFault(wdogFlt), .wdogAccessOkay(wdogOk), .irq(irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // mode inputs take one edge to reach the enables, but wait three
   task automatic setm(input logic s, input logic d, input logic a);
      @(posedge core_clk);
      sleepMode <= s;
      deepMode <= d;
      autoGate <= a;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic poke(input logic conv, input logic w);
      @(posedge core_clk);
      if (conv) convAcc <= '{valid: 1'h1, write: w};
      else wdogAcc <= '{valid: 1'h1, write: w};
      @(posedge core_clk);
      convAcc <= '0;
      wdogAcc <= '0;
      @(negedge core_clk);
   endtask
   task automatic t_reset;
      cpu.rd(scg_pkg::SCG_OFS_SLEEP_GATE, rdv, rsp);
      chk(rdv, scg_pkg::SCG_GATE_RESET);
      chk(32'({convEn, wdogEn, rate}), '0);
   endtask
   task automatic t_fields;
      cpu.wr(scg_pkg::SCG_OFS_SLEEP_GATE, 32'hffff_ffff, rsp);
      cpu.rd(scg_pkg::SCG_OFS_SLEEP_GATE, rdv, rsp);
      chk(rdv, 32'h0001_0348);
      cpu.wr(scg_pkg::SCG_OFS_SLEEP_GATE, 32'h0001_0148, rsp);
      setm(1, 0, 1);
      chk(32'(rate), 32'(scg_pkg::SCG_RATE_250K));
      cpu.wr(scg_pkg::SCG_OFS_SLEEP_GATE, 32'h0001_0040, rsp);
      setm(1, 0, 1);
      chk(32'(rate), 32'(scg_pkg::SCG_RATE_125K));
      cpu.rd(12'h0200, rdv, rsp);
      chk({rdv[29:0], rsp}, 32'(scg_pkg::SCG_RESP_DECERR));
      cpu.wr(12'h0200, 32'h0000_0000, rsp);
      chk(32'(rsp), 32'(scg_pkg::SCG_RESP_DECERR));
   endtask
   task automatic t_modes;
      chk(32'({convEn, wdogEn}), 32'h2);
      setm(1, 0, 0);
      chk(32'({convEn, wdogEn}), 32'h1);
      chk(32'(rate), 32'(scg_pkg::SCG_RATE_250K));
      setm(0, 1, 1);
      chk(32'({convEn, wdogEn}), 32'h3);
      setm(0, 0, 1);
      chk(32'({convEn, wdogEn}), 32'h1);
      chk(32'(rate), 32'(scg_pkg::SCG_RATE_250K));
   endtask
   task automatic t_fault;
      setm(1, 0, 1);
      poke(1, 0);
      chk(32'({convFlt, convOk}), 32'h1);
      poke(0, 1);
      chk(32'({wdogFlt, wdogOk}), 32'h2);
      setm(1, 0, 1);
      chk(32'(irq), 32'h0);
      cpu.wr(scg_pkg::SCG_OFS_IRQ_MASK, 32'h0000_0003, rsp);
      setm(1, 0, 1);
      chk(32'(irq), 32'h1);
      cpu.rd(scg_pkg::SCG_OFS_IRQ_STATUS, rdv, rsp);
      chk(rdv, 32'h0000_0002);
      cpu.wr(scg_pkg::SCG_OFS_IRQ_STATUS, 32'h0000_0002, rsp);
      setm(1, 0, 1);
      chk(32'(irq), 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge core_clk);
      arst_n <= 1'h1;
      t_reset();
      t_fields();
      t_modes();
      t_fault();
      // reset again after writes so the reset values are really restored
      arst_n <= 1'h0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'h1;
      t_reset();
      wrap_up();
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         wrap_up();
      end
   end
endmodule // tb_top
